// File: rtl/jdp_debug_port.sv
// What this block does
// RQ1: Sample test data in on test clock rise
// RQ2: Sample mode select on rise, advance controller
// RQ3: Drive test data out only in shift states
// RQ4: Change test data out on falling edges only
// RQ5: Test reset initialises controller without clock edge
// RQ6: Tester holds test reset through power-up
// RQ7: Event request: finish, save, enter debug, await
// RQ8: Event line driven open-drain as acknowledge
// RQ9: Acknowledge debug entry for exactly three cycles
// RQ10: Event line goes straight to debug unit
// RQ11: Other debug functions reached through test port
// RQ12: Standard sixteen-state controller, reset on test reset
`timescale 1ns/10ps
`default_nettype none

module jdp_debug_port (
  // Core clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Test access port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trstn,
  output logic tdoOut,
  output logic tdoEn,
  // Debug-event open-drain pin
  input wire logic debugEventIn,
  output logic debugEventOut,
  output logic debugEventEn,
  // Core side
  input wire logic instrDone,
  input wire logic breakpointHit,
  input wire logic debugExit,
  output logic debugMode,
  output logic savePipeline,
  output logic cmdValid,
  output logic [jdp_pkg::CMD_WIDTH-1:0] cmdData
);

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  jdp_pkg::jdp_state_t st_ff; // Registered state
  jdp_pkg::jdp_state_t nxt_st; // Next state
  logic savePulse_ff; // Pipeline save strobe
  logic nxt_savePulse; // Next save strobe

  // Decoded pin events
  logic tckRise; // Test clock rising edge
  logic tckFall; // Test clock falling edge
  logic trstLow; // Synchronised test reset active
  logic evtLow; // Synchronised event line low
  logic shifting; // Controller in a shift state

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_savePulse = 1'b0;
    // Two-stage synchronisers; logic reads stage 2 only
    nxt_st.sync.tck = {st_ff.sync.tck[0], tck};
    nxt_st.sync.tms = {st_ff.sync.tms[0], tms};
    nxt_st.sync.tdi = {st_ff.sync.tdi[0], tdi};
    nxt_st.sync.trst = {st_ff.sync.trst[0], ~trstn};
    nxt_st.sync.evt = {st_ff.sync.evt[0], debugEventIn};
    nxt_st.tckLast = st_ff.sync.tck[1];
    tckRise = st_ff.sync.tck[1] & ~st_ff.tckLast;
    tckFall = ~st_ff.sync.tck[1] & st_ff.tckLast;
    trstLow = st_ff.sync.trst[1];
    evtLow = ~st_ff.sync.evt[1] & ~st_ff.evtDriveLow;
    shifting = (st_ff.tap == jdp_pkg::SHIFT_DR) || (st_ff.tap == jdp_pkg::SHIFT_IR);
    nxt_st.cmdValid = 1'b0;

    // Rising edge: sample pins and step the controller
    if (tckRise) begin
      nxt_st.tmsSmp = st_ff.sync.tms[1]; // [RQ2]
      nxt_st.tdiSmp = st_ff.sync.tdi[1]; // [RQ1]
      case (st_ff.tap)
        jdp_pkg::TEST_LOGIC_RESET: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::TEST_LOGIC_RESET : jdp_pkg::RUN_TEST_IDLE; // [RQ12]
        end
        jdp_pkg::RUN_TEST_IDLE: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::SELECT_DR : jdp_pkg::RUN_TEST_IDLE;
        end
        jdp_pkg::SELECT_DR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::SELECT_IR : jdp_pkg::CAPTURE_DR;
        end
        jdp_pkg::CAPTURE_DR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::EXIT1_DR : jdp_pkg::SHIFT_DR;
          nxt_st.drShift = st_ff.cmdReg;
          nxt_st.bypassBit = 1'b0;
        end
        jdp_pkg::SHIFT_DR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::EXIT1_DR : jdp_pkg::SHIFT_DR;
          nxt_st.drShift = {st_ff.sync.tdi[1], st_ff.drShift[jdp_pkg::CMD_WIDTH-1:1]}; // [RQ1]
          nxt_st.bypassBit = st_ff.sync.tdi[1]; // [RQ1]
        end
        jdp_pkg::EXIT1_DR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::UPDATE_DR : jdp_pkg::PAUSE_DR;
        end
        jdp_pkg::PAUSE_DR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::EXIT2_DR : jdp_pkg::PAUSE_DR;
        end
        jdp_pkg::EXIT2_DR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::UPDATE_DR : jdp_pkg::SHIFT_DR;
        end
        jdp_pkg::UPDATE_DR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::SELECT_DR : jdp_pkg::RUN_TEST_IDLE;
          // Debug commands arrive through the test port
          if (st_ff.irReg == jdp_pkg::IR_DEBUG) begin
            nxt_st.cmdReg = st_ff.drShift; // [RQ11]
            nxt_st.cmdValid = st_ff.debugMode; // [RQ7]
          end
        end
        jdp_pkg::SELECT_IR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::TEST_LOGIC_RESET : jdp_pkg::CAPTURE_IR;
        end
        jdp_pkg::CAPTURE_IR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::EXIT1_IR : jdp_pkg::SHIFT_IR;
          nxt_st.irShift = jdp_pkg::IR_CAPTURE;
        end
        jdp_pkg::SHIFT_IR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::EXIT1_IR : jdp_pkg::SHIFT_IR;
          nxt_st.irShift = {st_ff.sync.tdi[1], st_ff.irShift[jdp_pkg::IR_WIDTH-1:1]}; // [RQ1]
        end
        jdp_pkg::EXIT1_IR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::UPDATE_IR : jdp_pkg::PAUSE_IR;
        end
        jdp_pkg::PAUSE_IR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::EXIT2_IR : jdp_pkg::PAUSE_IR;
        end
        jdp_pkg::EXIT2_IR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::UPDATE_IR : jdp_pkg::SHIFT_IR;
        end
        jdp_pkg::UPDATE_IR: begin
          nxt_st.tap = st_ff.sync.tms[1] ? jdp_pkg::SELECT_DR : jdp_pkg::RUN_TEST_IDLE;
          nxt_st.irReg = st_ff.irShift;
        end
        default: begin
          nxt_st.tap = jdp_pkg::TEST_LOGIC_RESET;
        end
      endcase
      if (st_ff.tap == jdp_pkg::TEST_LOGIC_RESET) begin
        nxt_st.irReg = jdp_pkg::IR_RESET;
      end
    end

    // Falling edge: update test data out and its enable
    if (tckFall) begin
      nxt_st.tdoEn = shifting; // [RQ3]
      if (st_ff.tap == jdp_pkg::SHIFT_IR) begin
        nxt_st.tdoOut = st_ff.irShift[0]; // [RQ4]
      end else if (st_ff.irReg == jdp_pkg::IR_DEBUG) begin
        nxt_st.tdoOut = st_ff.drShift[0]; // [RQ4]
      end else begin
        nxt_st.tdoOut = st_ff.bypassBit; // [RQ4]
      end
    end

    // Event line request straight into the debug unit
    if (evtLow && !st_ff.debugMode) begin
      nxt_st.debugReq = 1'b1; // [RQ10]
    end
    // Entry at instruction boundary, or on breakpoint
    if (!st_ff.debugMode && ((st_ff.debugReq && instrDone) || breakpointHit)) begin
      nxt_st.debugMode = 1'b1; // [RQ7]
      nxt_st.debugReq = 1'b0;
      nxt_savePulse = 1'b1; // [RQ7]
      nxt_st.ackCnt = jdp_pkg::ACK_CYCLES; // [RQ9]
      nxt_st.evtDriveLow = 1'b1; // [RQ8]
    end else if (st_ff.ackCnt != 2'h0) begin
      nxt_st.ackCnt = st_ff.ackCnt - 2'h1;
      nxt_st.evtDriveLow = (st_ff.ackCnt != 2'h1); // [RQ9]
    end
    // Core leaves debug mode
    if (st_ff.debugMode && debugExit) begin
      nxt_st.debugMode = 1'b0;
    end

    // Test reset forces the controller, no clock edge needed
    if (trstLow) begin
      nxt_st.tap = jdp_pkg::TEST_LOGIC_RESET; // [RQ5] [RQ12]
      nxt_st.irReg = jdp_pkg::IR_RESET;
      nxt_st.tdoEn = 1'b0; // [RQ3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.irReg <= jdp_pkg::IR_RESET;
      st_ff.tap <= jdp_pkg::TEST_LOGIC_RESET;
      st_ff.sync.tck <= 2'h0;
      st_ff.sync.evt <= 2'h3;
      savePulse_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      savePulse_ff <= nxt_savePulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops except debugEventOut, which is tied to constant 0
  assign tdoOut = st_ff.tdoOut;
  assign tdoEn = st_ff.tdoEn;
  assign debugEventOut = 1'b0; // Open drain: only pulls low
  assign debugEventEn = st_ff.evtDriveLow; // [RQ8]
  assign debugMode = st_ff.debugMode;
  assign savePipeline = savePulse_ff;
  assign cmdValid = st_ff.cmdValid;
  assign cmdData = st_ff.cmdReg;

endmodule

`default_nettype wire

// File: rtl/jdp_pkg.sv
package jdp_pkg;

  // Tap controller states, sixteen of them
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR,
    PAUSE_IR, EXIT2_IR, UPDATE_IR
  } jdp_tap_t;

  // Instruction register width
  localparam int IR_WIDTH = 4;
  // Debug-event acknowledge length in core clock cycles
  localparam logic [1:0] ACK_CYCLES = 2'h3;
  // Reset value of the instruction register
  localparam logic [IR_WIDTH-1:0] IR_RESET = 4'hF;
  // Instruction that selects the debug unit data path
  localparam logic [IR_WIDTH-1:0] IR_DEBUG = 4'h8;
  // Value captured into the instruction register
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
  // Width of the debug-unit command register
  localparam int CMD_WIDTH = 8;

  // Synchronised pin samples
  typedef struct packed {
    logic [1:0] tck;
    logic [1:0] tms;
    logic [1:0] tdi;
    logic [1:0] trst;
    logic [1:0] evt;
  } jdp_sync_t;

  // Whole module state
  typedef struct packed {
    jdp_sync_t sync;
    logic tckLast;
    logic tmsSmp;
    logic tdiSmp;
    jdp_tap_t tap;
    logic [IR_WIDTH-1:0] irShift;
    logic [IR_WIDTH-1:0] irReg;
    logic [CMD_WIDTH-1:0] drShift;
    logic [CMD_WIDTH-1:0] cmdReg;
    logic bypassBit;
    logic tdoOut;
    logic tdoEn;
    logic debugMode;
    logic debugReq;
    logic cmdValid;
    logic [1:0] ackCnt;
    logic evtDriveLow;
  } jdp_state_t;

endpackage

// File: tb/jdp_debug_port_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Port checker for the test port and event line
module jdp_debug_port_assertions (
  // Core clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Test pins
  input wire logic tck,
  input wire logic trstn,
  input wire logic tdoOut,
  input wire logic tdoEn,
  // Event line and core side
  input wire logic debugEventIn,
  input wire logic debugEventOut,
  input wire logic debugEventEn,
  input wire logic instrDone,
  input wire logic breakpointHit,
  input wire logic debugMode,
  input wire logic savePipeline,
  input wire logic cmdValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  AST_OD_LOW: assert property (debugEventOut == 1'b0) else $error("event line driven high");
  AST_ACK_LEN: assert property ($rose(debugEventEn) |-> debugEventEn [*3] ##1 !debugEventEn)
    else $error("ack length wrong");
  AST_ACK_CAUSE: assert property ($rose(debugEventEn) |-> $rose(debugMode)) else $error("ack without entry");
  AST_ENTRY: assert property ($rose(debugMode) |-> debugEventEn && savePipeline) else $error("entry no ack");
  AST_SAVE: assert property (savePipeline |-> debugMode) else $error("save outside debug");
  AST_TDO_EDGE: assert property ($changed(tdoOut) |-> !tck) else $error("tdo moved while tck high");
  AST_TDO_EN: assert property ($changed(tdoEn) |-> !tck) else $error("tdo enable off falling edge");
  AST_TRST: assert property (!trstn [*5] |-> !tdoEn) else $error("tdo driven in test reset");
  AST_RST: assert property (disable iff (1'b0) !rstn |=> !tdoEn && !debugEventEn && !debugMode)
    else $error("outputs active in reset");
  AST_EVT: assert property ((!debugEventIn && instrDone && !debugMode && !debugEventEn) [*4] |-> ##[0:3] debugMode)
    else $error("event request not taken");
  AST_BP: assert property (breakpointHit && !debugMode |-> ##[1:2] debugMode) else $error("breakpoint ignored");
  AST_CMD: assert property (cmdValid |-> debugMode) else $error("command outside debug");
  // Main scenarios reached
  cover property ($rose(debugMode));
  cover property (cmdValid);
  cover property ($rose(tdoEn));
endmodule
bind jdp_debug_port jdp_debug_port_assertions chk (.clk(clk), .rstn(rstn), .tck(tck), .trstn(trstn),
  .tdoOut(tdoOut), .tdoEn(tdoEn), .debugEventIn(debugEventIn), .debugEventOut(debugEventOut),
  .debugEventEn(debugEventEn), .instrDone(instrDone), .breakpointHit(breakpointHit),
  .debugMode(debugMode), .savePipeline(savePipeline), .cmdValid(cmdValid));
`default_nettype wire

// File: tb/jdp_debug_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
// Bench for the test port and event line
module jdp_debug_port_tb;
  // Core-side stimulus
  logic clk = 1'b0, rstn = 1'b0, instrDone = 1'b0, breakpointHit = 1'b0, debugExit = 1'b0;
  // Pins and outputs
  logic tck, tms, tdi, trstn, evtPull, tdoOut, tdoEn, debugEventOut, debugEventEn;
  logic debugMode, savePipeline, cmdValid, o;
  logic [7:0] cmdData, got;
  wire logic debugEventIn;
  int errors = 0, tests_run = 0, ackCycles = 0, savePulses = 0, cmdPulses = 0;
  always #4 clk = ~clk;
  // Open-drain line with pull-up
  assign debugEventIn = (debugEventEn ? debugEventOut : 1'b1) & ~evtPull;
  // Pulse counters
  always @(posedge clk) begin
    ackCycles <= ackCycles + int'(debugEventEn);
    savePulses <= savePulses + int'(savePipeline);
    cmdPulses <= cmdPulses + int'(cmdValid);
  end
  jdp_debug_port dut (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .trstn(trstn), .tdoOut(tdoOut),
    .tdoEn(tdoEn), .debugEventIn(debugEventIn), .debugEventOut(debugEventOut), .debugEventEn(debugEventEn),
    .instrDone(instrDone), .breakpointHit(breakpointHit), .debugExit(debugExit), .debugMode(debugMode),
    .savePipeline(savePipeline), .cmdValid(cmdValid), .cmdData(cmdData));
  jdp_tester tst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trstn(trstn), .evtPull(evtPull), .tdoOut(tdoOut),
    .tdoEn(tdoEn));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait of 100 core cycles for debug mode level, run stopped if it never comes
  task automatic wait_mode(input logic v);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      #1;
      if (debugMode === v) return;
    end
    errors++;
    $display("unexpected at %0t: debug mode wait ran out", $time);
    report_and_stop();
  endtask
  task automatic leave_debug();
    @(posedge clk) debugExit <= 1'b1;
    @(posedge clk) debugExit <= 1'b0;
    wait_mode(1'b0);
    clear_counts();
  endtask
  // Clear pulse counters off the clock edge, clear of their own updates
  task automatic clear_counts();
    #1;
    ackCycles = 0;
    savePulses = 0;
    cmdPulses = 0;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_scan();
    tst.scan(1'b0, 8, 8'h5A, got);
    check(got, 8'hB4);
    tst.scan(1'b1, 4, {4'h0, jdp_pkg::IR_DEBUG}, got);
    check(got, {4'h0, jdp_pkg::IR_CAPTURE});
    clear_counts();
    tst.scan(1'b0, 8, 8'hC3, got);
    check(got, 8'h00);
    check(8'(cmdPulses), 8'h00);
    check(cmdData, 8'hC3);
    $display("test scan done");
  endtask
  task automatic t_event();
    tst.set_pull(1'b1);
    repeat (10) @(posedge clk);
    check(debugMode, 1'b0);
    @(posedge clk) instrDone <= 1'b1;
    wait_mode(1'b1);
    tst.set_pull(1'b0);
    repeat (8) @(posedge clk);
    check(8'(ackCycles), 8'h03);
    check(8'(savePulses), 8'h01);
    $display("test event done");
  endtask
  task automatic t_cmd_refuse();
    clear_counts();
    tst.scan(1'b0, 8, 8'hA5, got);
    check(got, 8'hC3);
    check(8'(cmdPulses), 8'h01);
    check(cmdData, 8'hA5);
    tst.set_pull(1'b1);
    repeat (12) @(posedge clk);
    tst.set_pull(1'b0);
    check(8'(ackCycles), 8'h00);
    leave_debug();
    $display("test command done");
  endtask
  task automatic t_break();
    @(posedge clk) breakpointHit <= 1'b1;
    @(posedge clk) breakpointHit <= 1'b0;
    wait_mode(1'b1);
    repeat (6) @(posedge clk);
    check(8'(ackCycles), 8'h03);
    leave_debug();
    $display("test breakpoint done");
  endtask
  // Event request while the core already sits at an instruction boundary
  task automatic t_event_ready();
    tst.set_pull(1'b1);
    wait_mode(1'b1);
    tst.set_pull(1'b0);
    repeat (6) @(posedge clk);
    check(8'(ackCycles), 8'h03);
    check(8'(savePulses), 8'h01);
    leave_debug();
    $display("test ready event done");
  endtask
  task automatic t_trst();
    tst.tbit(1'b1, 1'b1, o);
    tst.tbit(1'b0, 1'b1, o);
    tst.tbit(1'b0, 1'b1, o);
    repeat (5) @(posedge clk);
    check(tdoEn, 1'b1);
    tst.pulse_trst();
    check(tdoEn, 1'b0);
    tst.tbit(1'b0, 1'b1, o);
    tst.scan(1'b1, 4, 8'h0F, got);
    check(got, {4'h0, jdp_pkg::IR_CAPTURE});
    $display("test trst done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    check(tdoEn, 1'b0);
    tst.pulse_trst();
    tst.tbit(1'b0, 1'b1, o);
    t_scan();
    t_event();
    t_cmd_refuse();
    t_break();
    t_event_ready();
    t_trst();
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: tb/jdp_tester.sv
`timescale 1ns/10ps
`default_nettype none
// Tester model: test pins and event line pull
module jdp_tester (
  // Core clock that paces the pins
  input wire logic clk,
  // Drives toward the port
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trstn,
  output logic evtPull,
  // Answers from the port
  input wire logic tdoOut,
  input wire logic tdoEn
);
  // Tck stands low outside frames, test reset held from power-up
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trstn = 1'b0;
    evtPull = 1'b0;
  end
  // One tck period of ten core cycles, tdo taken at the rising edge
  task automatic tbit(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge clk);
    o = tdoEn ? tdoOut : 1'bz;
    tck <= 1'b1;
    repeat (5) @(posedge clk);
    tck <= 1'b0;
  endtask
  // Scan from idle through IR or DR and back to idle
  task automatic scan(input logic ir, input int n, input logic [7:0] din, output logic [7:0] dout);
    logic o;
    dout = 8'h00;
    tbit(1'b1, 1'b1, o);
    if (ir) tbit(1'b1, 1'b1, o);
    tbit(1'b0, 1'b1, o);
    tbit(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) tbit(i == n - 1, din[i], dout[i]);
    tbit(1'b1, 1'b1, o);
    tbit(1'b0, 1'b1, o);
  endtask
  // Test reset pulse of ten core cycles
  task automatic pulse_trst();
    @(posedge clk);
    trstn <= 1'b0;
    repeat (10) @(posedge clk);
    trstn <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  // Request or release debug entry
  task automatic set_pull(input logic v);
    @(posedge clk);
    evtPull <= v;
  endtask
endmodule
`default_nettype wire
